/* design/pooc_pkg.sv */
// What this block does
// - Enabled channel driven by software level bit
// - Enable writes buffered until commutation when enabled
// - Level writes buffered until commutation when enabled
// - Odd level in complementary mode is gated off while the even partner's level is high
// - Level reads undefined with async fault; mask (always defined here, no fault input)
// - Deadtime sample register is read-only
// - Sample pairs show the latched sense input; method 01 latches it at deadtime end
// - Sense method field selects correction scheme
// - Method 10 latches while both pair outputs off
// - Method 11 samples at half or cycle end
// - Sense method field takes effect at once
// - Low sense input means positive current
// - Polarity bit picks even or odd value register
// - Polarity bits buffered to next cycle start
// - No correction releases sense inputs as GPIO
`default_nettype none
package pooc_pkg;
    localparam logic [3:0] off_sw_output_enable = 4'h0;
    localparam logic [3:0] off_sw_output_level = 4'h4;
    localparam logic [3:0] off_deadtime_sense_sample = 4'h8;
    localparam logic [3:0] off_correction_control = 4'hc;
    localparam logic [5:0] reset_six = 6'h00;
    localparam logic [2:0] reset_three = 3'h0;
    localparam logic [1:0] reset_method = 2'h0;
    localparam int sense_method_lsb = 4;
    localparam logic [1:0] method_none = 2'h0;
    localparam logic [1:0] method_manual = 2'h1;
    localparam logic [1:0] method_deadtime = 2'h2;
    localparam logic [1:0] method_cycle = 2'h3;
endpackage : pooc_pkg
`default_nettype wire

/* design/pooc_sense_if.sv */
`default_nettype none
interface pooc_sense_if;
    logic [2:0] sense_sample;
    logic [2:0] sense_latched;
    modport ctrl (input sense_latched, output sense_sample);
    modport capt (input sense_sample, output sense_latched);
endinterface : pooc_sense_if
`default_nettype wire

/* design/pooc_sense_capture.sv */
`default_nettype none
module pooc_sense_capture (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic srst,
    // Sense inputs and capture strobes
    input wire logic [2:0] current_sense_input,
    pooc_sense_if.capt sif
);
    typedef struct packed {
        logic [2:0] latched;
    } pooc_cap_state_type;
    pooc_cap_state_type state, next_state;

    always_comb begin
        next_state = state;
        for (int i = 0; i < 3; i++) begin
            if (sif.sense_sample[i]) begin
                next_state.latched[i] = current_sense_input[i];
            end
        end
    end

    always_ff @(posedge ref_clk) begin
        if (srst) begin
            state <= '{latched: pooc_pkg::reset_three};
        end else begin
            state <= next_state;
        end
    end

    assign sif.sense_latched = state.latched;
endmodule : pooc_sense_capture
`default_nettype wire

/* design/pooc_override.sv */
`default_nettype none
module pooc_override (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic srst,
    // Control
    input wire logic complementary_mode,
    input wire logic [5:0] active_enable,
    input wire logic [5:0] active_level,
    input wire logic [5:0] pwm_in,
    // Result
    output logic [5:0] pwm_out
);
    typedef struct packed {
        logic [5:0] out;
    } pooc_ovr_state_type;
    pooc_ovr_state_type state, next_state;

    always_comb begin
        next_state = state;
        for (int i = 0; i < 6; i++) begin
            if (!active_enable[i]) begin
                next_state.out[i] = pwm_in[i];
            end else if (complementary_mode && i[0]) begin
                next_state.out[i] = active_level[i] & ~active_level[i - 1];
            end else begin
                next_state.out[i] = active_level[i];
            end
        end
    end

    always_ff @(posedge ref_clk) begin
        if (srst) begin
            state <= '{out: pooc_pkg::reset_six};
        end else begin
            state <= next_state;
        end
    end

    assign pwm_out = state.out;
endmodule : pooc_override
`default_nettype wire

/* design/pooc_top.sv */
// The implementer's own choices: the address map and register access over Avalon-MM.
`default_nettype none
module pooc_top (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic srst,
    // Avalon-MM slave
    input wire logic [3:0] address,
    input wire logic read,
    input wire logic write,
    input wire logic [31:0] writedata,
    input wire logic [3:0] byteenable,
    output logic [31:0] readdata,
    output logic waitrequest,
    // PWM core interface
    input wire logic commutation_strobe,
    input wire logic cycle_start_strobe,
    input wire logic half_cycle_strobe,
    input wire logic center_aligned,
    input wire logic complementary_mode,
    input wire logic commutation_buffer_enable,
    input wire logic [5:0] modulated_output_n,
    input wire logic [2:0] pair_both_off,
    input wire logic [2:0] deadtime_end_strobe,
    // Pins
    input wire logic [2:0] current_sense_input,
    output logic [5:0] pwm_out,
    // Correction outputs
    output logic [1:0] sense_method,
    output logic [2:0] value_select,
    output logic [2:0] sense_current_negative,
    output logic sense_gpio_release
);
    typedef struct packed {
        logic [5:0] buf_enable;
        logic [5:0] act_enable;
        logic [5:0] buf_level;
        logic [5:0] act_level;
        logic [1:0] method;
        logic [2:0] buf_select;
        logic [2:0] act_select;
        logic [31:0] rdata;
        logic waitreq;
    } pooc_top_state_type;
    pooc_top_state_type state, next_state;

    pooc_sense_if sif ();
    logic [5:0] dt_bits;
    logic req;
    logic [2:0] sample_now;

    pooc_sense_capture u_capture (
        .ref_clk(ref_clk),
        .srst(srst),
        .current_sense_input(current_sense_input),
        .sif(sif.capt)
    );

    pooc_override u_override (
        .ref_clk(ref_clk),
        .srst(srst),
        .complementary_mode(complementary_mode),
        .active_enable(state.act_enable),
        .active_level(state.act_level),
        .pwm_in(modulated_output_n),
        .pwm_out(pwm_out)
    );

    // Taken only while waitrequest is still high, so a held request is not taken twice
    assign req = (read | write) & state.waitreq;

    // Capture strobes depend on method; no capture when correction is off
    always_comb begin
        sample_now = pooc_pkg::reset_three;
        unique case (state.method)
            pooc_pkg::method_none: sample_now = pooc_pkg::reset_three;
            pooc_pkg::method_manual: sample_now = deadtime_end_strobe;
            // Latch only inside deadtime; 0%/100% duty never raises both-off
            pooc_pkg::method_deadtime: sample_now = pair_both_off;
            pooc_pkg::method_cycle: begin
                sample_now = {3{center_aligned ? half_cycle_strobe : cycle_start_strobe}};
            end
        endcase
    end
    assign sif.sense_sample = sample_now;
    // Each pair shows its sense input on both bits
    assign dt_bits = {{2{sif.sense_latched[2]}}, {2{sif.sense_latched[1]}}, {2{sif.sense_latched[0]}}};

    always_comb begin
        next_state = state;
        // One wait state per request, then waitrequest low for one cycle
        next_state.waitreq = ~req;
        // Strobes move buffered values into active copies first
        if (!commutation_buffer_enable || commutation_strobe) begin
            next_state.act_enable = state.buf_enable;
            next_state.act_level = state.buf_level;
        end
        if (cycle_start_strobe) begin
            next_state.act_select = state.buf_select;
        end
        if (req && write && byteenable[0]) begin
            unique case (address)
                pooc_pkg::off_sw_output_enable: next_state.buf_enable = writedata[5:0];
                pooc_pkg::off_sw_output_level: next_state.buf_level = writedata[5:0];
                pooc_pkg::off_correction_control: begin
                    next_state.method = writedata[pooc_pkg::sense_method_lsb +: 2];
                    next_state.buf_select = writedata[2:0];
                end
                default: ; // Sample register ignores writes
            endcase
        end
        next_state.rdata = '0;
        if (req && read) begin
            unique case (address)
                pooc_pkg::off_sw_output_enable: next_state.rdata = {26'h0, state.buf_enable};
                // Level reads are always defined here; software may still mask
                pooc_pkg::off_sw_output_level: next_state.rdata = {26'h0, state.buf_level};
                pooc_pkg::off_deadtime_sense_sample: next_state.rdata = {26'h0, dt_bits};
                pooc_pkg::off_correction_control: begin
                    next_state.rdata = {26'h0, state.method, 1'b0, state.buf_select};
                end
                default: next_state.rdata = '0;
            endcase
        end
    end

    always_ff @(posedge ref_clk) begin
        if (srst) begin
            state <= '{waitreq: 1'b1, default: '0};
        end else begin
            state <= next_state;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (srst) begin
            sense_method <= pooc_pkg::reset_method;
            value_select <= pooc_pkg::reset_three;
            sense_current_negative <= pooc_pkg::reset_three;
            sense_gpio_release <= 1'b1;
        end else begin
            sense_method <= next_state.method;
            value_select <= next_state.act_select;
            // High input means negative current
            sense_current_negative <= sif.sense_latched;
            sense_gpio_release <= (next_state.method == pooc_pkg::method_none);
        end
    end

    assign readdata = state.rdata;
    assign waitrequest = state.waitreq;
endmodule : pooc_top
`default_nettype wire

/* testbench/pooc_checker.sv */
`default_nettype none
module pooc_checker (
    // Clock, reset and bus
    input wire logic ref_clk,
    input wire logic srst,
    input wire logic [3:0] address,
    input wire logic read,
    input wire logic write,
    input wire logic [31:0] writedata,
    input wire logic [3:0] byteenable,
    input wire logic waitrequest,
    // Core, pins and correction
    input wire logic cycle_start_strobe,
    input wire logic half_cycle_strobe,
    input wire logic center_aligned,
    input wire logic [2:0] pair_both_off,
    input wire logic [2:0] deadtime_end_strobe,
    input wire logic [2:0] current_sense_input,
    input wire logic [1:0] sense_method,
    input wire logic [2:0] value_select,
    input wire logic [2:0] sense_current_negative,
    input wire logic sense_gpio_release
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking @(posedge ref_clk); endclocking
    default disable iff (srst);
    // A write is taken at the edge where it first meets waitrequest high
    wire ctl_wr = write && waitrequest && address == pooc_pkg::off_correction_control && byteenable[0];
    // Capture lands in the sense flop, then one more cycle to the output
    sequence edge_pick; sense_method == pooc_pkg::method_cycle && cycle_start_strobe && !center_aligned; endsequence
    sequence center_pick; sense_method == pooc_pkg::method_cycle && half_cycle_strobe && center_aligned; endsequence
    sequence req_start; $rose(read || write); endsequence
    sequence answered; !waitrequest ##1 waitrequest; endsequence
    AST_BUS: assert property (req_start |=> answered) else $error("bus answer late");
    AST_METHOD: assert property (ctl_wr |=> sense_method == $past(writedata[5:4]))
        else $error("method not taken");
    AST_METH_HOLD: assert property (!ctl_wr |=> $stable(sense_method)) else $error("method moved");
    AST_GPIO: assert property (sense_gpio_release == (sense_method == pooc_pkg::method_none))
        else $error("gpio release wrong");
    AST_POL_HOLD: assert property (!cycle_start_strobe |=> $stable(value_select))
        else $error("polarity moved early");
    AST_M01: assert property (sense_method == pooc_pkg::method_manual && deadtime_end_strobe[0] |=> ##1
        sense_current_negative[0] == $past(current_sense_input[0], 2)) else $error("manual capture");
    AST_M10: assert property (sense_method == pooc_pkg::method_deadtime && pair_both_off[1] |=> ##1
        sense_current_negative[1] == $past(current_sense_input[1], 2)) else $error("deadtime capture");
    AST_M11: assert property (edge_pick |=> ##1 sense_current_negative == $past(current_sense_input, 2))
        else $error("cycle capture");
    AST_M11C: assert property (center_pick |=> ##1 sense_current_negative == $past(current_sense_input, 2))
        else $error("half cycle capture");
endmodule : pooc_checker
bind pooc_top pooc_checker chk_u (.ref_clk, .srst, .address, .read, .write, .writedata, .byteenable,
    .waitrequest, .cycle_start_strobe, .half_cycle_strobe, .center_aligned, .pair_both_off, .deadtime_end_strobe,
    .current_sense_input, .sense_method, .value_select, .sense_current_negative, .sense_gpio_release);
`default_nettype wire

/* testbench/pooc_power_stage.sv */
`default_nettype none
module pooc_power_stage (
    // Phase current direction
    input wire logic [2:0] phase_positive,
    // Sense pins
    output logic [2:0] current_sense_input
);
    timeunit 1ns;
    timeprecision 1ns;
    // Sense circuit pulls low for positive current
    assign current_sense_input = ~phase_positive;
endmodule : pooc_power_stage
`default_nettype wire

/* testbench/pooc_test.sv */
`default_nettype none
module pooc_test;
    timeunit 1ns;
    timeprecision 1ns;
    logic ref_clk = 1'b0;
    logic srst = 1'b1;
    logic [3:0] address = 4'h0;
    logic read = 1'b0;
    logic write = 1'b0;
    logic [31:0] writedata = 32'h0;
    logic [31:0] readdata;
    logic waitrequest;
    logic [2:0] st = 3'h0;
    logic [2:0] mode = 3'h0;
    logic [2:0] both_off = 3'h0;
    logic [2:0] dead_end = 3'h0;
    logic [2:0] positive = 3'h2;
    logic [5:0] pwm_gen = 6'h30;
    logic [2:0] sense, value_select, sense_neg;
    logic [5:0] pwm_out;
    logic [1:0] sense_method;
    logic gpio_rel;
    int n_mismatch = 0;
    int num_checks = 0;
    always #20 ref_clk = ~ref_clk;
    pooc_power_stage ps_u (.phase_positive(positive), .current_sense_input(sense));
    pooc_top dut_u (.ref_clk(ref_clk), .srst(srst), .address(address), .read(read), .write(write),
        .writedata(writedata), .byteenable(4'hf), .readdata(readdata), .waitrequest(waitrequest),
        .commutation_strobe(st[0]), .cycle_start_strobe(st[1]), .half_cycle_strobe(st[2]),
        .center_aligned(mode[2]), .complementary_mode(mode[1]), .commutation_buffer_enable(mode[0]),
        .modulated_output_n(pwm_gen), .pair_both_off(both_off), .deadtime_end_strobe(dead_end),
        .current_sense_input(sense), .pwm_out(pwm_out), .sense_method(sense_method),
        .value_select(value_select), .sense_current_negative(sense_neg), .sense_gpio_release(gpio_rel));
    task automatic tick(input int n);
        repeat (n) @(posedge ref_clk);
    endtask : tick
    task automatic chk(input string what, input logic [31:0] e, input logic [31:0] g);
        num_checks++;
        if (g !== e) begin
            n_mismatch++;
            $display("ERROR %s expected %h seen %h", what, e, g);
        end
    endtask : chk
    // Request held until waitrequest is seen low at an edge
    task automatic bus(input logic rd, input logic [3:0] a, input logic [7:0] d, input logic [7:0] e);
        read <= rd;
        write <= ~rd;
        address <= a;
        writedata <= {24'h0, d};
        tick(1);
        while (waitrequest !== 1'b0) tick(1);
        if (rd) chk($sformatf("reg %h", a), {24'h0, e}, readdata);
        read <= 1'b0;
        write <= 1'b0;
        tick(1);
    endtask : bus
    task automatic pulse(input logic [2:0] s);
        st <= s;
        tick(1);
        st <= 3'h0;
        tick(2);
    endtask : pulse
    task automatic stop_test;
        if (n_mismatch == 0 && num_checks > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : stop_test
    initial begin
        #400000;
        n_mismatch++;
        stop_test();
    end
    initial begin
        tick(20);
        srst <= 1'b0;
        tick(1);
        bus(1, 4'h0, 0, 8'h00);
        bus(1, 4'hc, 0, 8'h00);
        bus(0, 4'h0, 8'h3f, 0);
        bus(0, 4'h4, 8'h2a, 0);
        tick(3);
        chk("pwm_out", 6'h2a, pwm_out);
        mode <= 3'b010;
        bus(0, 4'h4, 8'h3f, 0);
        tick(3);
        chk("pwm_out", 6'h15, pwm_out);
        mode <= 3'b011;
        bus(0, 4'h4, 8'h00, 0);
        bus(1, 4'h4, 0, 8'h00);
        bus(0, 4'h0, 8'h0f, 0);
        bus(1, 4'h0, 0, 8'h0f);
        chk("pwm_out", 6'h15, pwm_out);
        pulse(3'b001);
        chk("pwm_out", 6'h30, pwm_out);
        bus(0, 4'hc, 8'h10, 0);
        dead_end <= 3'h7;
        tick(1);
        dead_end <= 3'h0;
        tick(2);
        bus(1, 4'h8, 0, 8'h33);
        chk("sense_neg", 3'h5, sense_neg);
        bus(0, 4'h8, 8'h00, 0);
        bus(1, 4'h8, 0, 8'h33);
        bus(0, 4'hc, 8'h15, 0);
        bus(1, 4'hc, 0, 8'h15);
        chk("value_select", 3'h0, value_select);
        pulse(3'b010);
        chk("value_select", 3'h5, value_select);
        for (int m = 0; m < 4; m++) begin
            bus(0, 4'hc, 8'(m << 4), 0);
            both_off <= 3'h7;
            positive <= 3'(m + 4);
            pulse(3'b110);
            both_off <= 3'h0;
            chk("gpio", m == 0, gpio_rel);
            chk("method", m, sense_method);
            chk("sense_neg", (m < 2) ? 3'h5 : 3'(3 - m), sense_neg);
        end
        mode <= 3'b111;
        positive <= 3'h2;
        pulse(3'b010);
        chk("sense_neg", 3'h0, sense_neg);
        pulse(3'b100);
        chk("sense_neg", 3'h5, sense_neg);
        srst <= 1'b1;
        tick(2);
        srst <= 1'b0;
        tick(1);
        chk("gpio", 1'b1, gpio_rel);
        bus(1, 4'h0, 0, 8'h00);
        bus(1, 4'h6, 0, 8'h00);
        stop_test();
    end
endmodule : pooc_test
`default_nettype wire
